// ---- crs_cfg.svh ----
// Constants for the core register set: map, flag layout, limits
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH
// Register select codes; byte offset on the bus is code times four
`define CRS_SEL_DAT0 4'h0
`define CRS_SEL_DAT1 4'h1
`define CRS_SEL_DAT2 4'h2
`define CRS_SEL_DAT3 4'h3
`define CRS_SEL_ADR0 4'h4
`define CRS_SEL_ADR1 4'h5
`define CRS_SEL_SB 4'h6
`define CRS_SEL_FB 4'h7
`define CRS_SEL_PC 4'h8
`define CRS_SEL_VECTOR_TABLE_BASE 4'h9
`define CRS_SEL_USP 4'hA
`define CRS_SEL_ISP 4'hB
`define CRS_SEL_FLG 4'hC
`define CRS_SEL_SP 4'hD
`define CRS_SEL_LONG_LO 4'hE
`define CRS_SEL_LONG_HI 4'hF
// Address bits covered by the map
`define CRS_MAP_BITS 6
// Flag register field positions
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_I 6
`define CRS_FLG_U 7
`define CRS_IPL_LSB 12
`define CRS_IPL_MSB 14
// Implemented flag bits; the rest are reserved
`define CRS_FLG_MASK 16'h70FF
// Highest software interrupt number that forces the interrupt stack
`define CRS_SWI_U_MAX 8'h1F
`endif

// ---- crs_pkg.sv ----
// Types shared by the core register set modules
`include "crs_cfg.svh"
package crs_pkg;
  typedef enum logic [3:0] {
    CRS_R_DAT0 = `CRS_SEL_DAT0,
    CRS_R_DAT1 = `CRS_SEL_DAT1,
    CRS_R_DAT2 = `CRS_SEL_DAT2,
    CRS_R_DAT3 = `CRS_SEL_DAT3,
    CRS_R_ADR0 = `CRS_SEL_ADR0,
    CRS_R_ADR1 = `CRS_SEL_ADR1,
    CRS_R_SB = `CRS_SEL_SB,
    CRS_R_FB = `CRS_SEL_FB,
    CRS_R_PC = `CRS_SEL_PC,
    CRS_R_VECTOR_TABLE_BASE = `CRS_SEL_VECTOR_TABLE_BASE,
    CRS_R_USP = `CRS_SEL_USP,
    CRS_R_ISP = `CRS_SEL_ISP,
    CRS_R_FLG = `CRS_SEL_FLG,
    CRS_R_SP = `CRS_SEL_SP,
    CRS_R_LONG_LO = `CRS_SEL_LONG_LO,
    CRS_R_LONG_HI = `CRS_SEL_LONG_HI
  } crs_sel_t;

  typedef enum logic [1:0] {
    CRS_SZ_WORD = 2'h0,
    CRS_SZ_LOW = 2'h1,
    CRS_SZ_HIGH = 2'h2
  } crs_size_t;

  // Banked: data words, address pointers, frame base
  typedef struct packed {
    logic [1:0][3:0][15:0] dat;
    logic [1:0][1:0][23:0] adr;
    logic [1:0][23:0] fbs;
    logic [23:0] sb;
    logic [23:0] pc;
    logic [23:0] vector_table_base;
    logic [23:0] user_stack_pointer;
    logic [23:0] irq_stack_pointer;
    logic [15:0] processor_flags;
    logic ack;
    logic [31:0] bus_rd;
    logic [31:0] rd;
  } crs_state_t;
endpackage

// ---- crs_regfile.sv ----
// Programmer-visible register set of the CPU core with Wishbone access
//
// Summary of operation
// - Four 16-bit data words; two split bytes
// - Words zero/two and one/three pair as 32-bit
// - Two 24-bit address pointers
// - Separate 24-bit static and frame bases
// - 24-bit program counter holds next address
// - 24-bit relocatable vector table base
// - Stack select flag picks irq or user pointer
// - Hardware ack, low software interrupt clear select
// - 16-bit flag register holds processor state
// - Carry flag shows carry or borrow
// - Zero flag set on zero result
// - Sign flag set on negative result
// - Bank flag selects register bank
// - Overflow flag set on overflow
// - Enable flag masks maskable interrupts
// - Interrupt acknowledge clears enable flag
// - Accept request only above priority level
// - Reserved flag bits written zero, read undefined
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "crs_cfg.svh"
module crs_regfile #(
  parameter int ADR_W = 8,
  parameter int SWI_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Result write-back from the datapath
  input wire logic res_en_i,
  input wire crs_pkg::crs_sel_t res_sel_i,
  input wire crs_pkg::crs_size_t res_size_i,
  input wire logic [31:0] res_data_i,
  input wire logic upd_c_i,
  input wire logic upd_z_i,
  input wire logic upd_s_i,
  input wire logic upd_o_i,
  input wire logic carry_i,
  input wire logic ovf_i,
  // Program counter load
  input wire logic pc_load_i,
  input wire logic [23:0] pc_next_i,
  // Datapath read port
  input wire crs_pkg::crs_sel_t rd_sel_i,
  output logic [31:0] rd_data_o,
  // Interrupt sequencer
  input wire logic irq_req_i,
  input wire logic [2:0] irq_pri_i,
  output logic irq_accept_o,
  input wire logic irq_ack_i,
  input wire logic swi_i,
  input wire logic [SWI_W-1:0] swi_num_i,
  // Core state
  output logic [23:0] pc_o,
  output logic [23:0] sp_o,
  output logic [23:0] vector_table_base_o,
  output logic [15:0] flags_o
);
  crs_pkg::crs_state_t s_reg;
  crs_pkg::crs_state_t s_next;
  logic res_zero;
  logic res_sign;
  logic bus_req;
  logic unmapped;

  ////////////////////////////////////////////////////////////////////////
  // Register access helpers

  function automatic logic [31:0] rd_reg(crs_pkg::crs_state_t s,
                                         logic [3:0] i);
    logic b;
    b = s.processor_flags[`CRS_FLG_B];
    rd_reg = 32'h00000000;
    unique case (i)
      crs_pkg::CRS_R_DAT0, crs_pkg::CRS_R_DAT1,
      crs_pkg::CRS_R_DAT2, crs_pkg::CRS_R_DAT3: begin
        rd_reg = {16'h0000, s.dat[b][i[1:0]]};
      end
      crs_pkg::CRS_R_ADR0, crs_pkg::CRS_R_ADR1: begin
        rd_reg = {8'h00, s.adr[b][i[0]]};
      end
      crs_pkg::CRS_R_SB: rd_reg = {8'h00, s.sb};
      crs_pkg::CRS_R_FB: rd_reg = {8'h00, s.fbs[b]};
      crs_pkg::CRS_R_PC: rd_reg = {8'h00, s.pc};
      crs_pkg::CRS_R_VECTOR_TABLE_BASE: rd_reg = {8'h00, s.vector_table_base};
      crs_pkg::CRS_R_USP: rd_reg = {8'h00, s.user_stack_pointer};
      crs_pkg::CRS_R_ISP: rd_reg = {8'h00, s.irq_stack_pointer};
      crs_pkg::CRS_R_FLG: rd_reg = {16'h0000, s.processor_flags};
      crs_pkg::CRS_R_SP: begin
        rd_reg = {8'h00, s.processor_flags[`CRS_FLG_U] ? s.user_stack_pointer : s.irq_stack_pointer};
      end
      crs_pkg::CRS_R_LONG_LO: begin
        rd_reg = {s.dat[b][2], s.dat[b][0]};
      end
      crs_pkg::CRS_R_LONG_HI: begin
        rd_reg = {s.dat[b][3], s.dat[b][1]};
      end
    endcase
  endfunction

  function automatic crs_pkg::crs_state_t put(crs_pkg::crs_state_t s,
                                              logic [3:0] i,
                                              logic [31:0] v);
    logic b;
    b = s.processor_flags[`CRS_FLG_B];
    put = s;
    unique case (i)
      crs_pkg::CRS_R_DAT0, crs_pkg::CRS_R_DAT1,
      crs_pkg::CRS_R_DAT2, crs_pkg::CRS_R_DAT3: begin
        put.dat[b][i[1:0]] = v[15:0];
      end
      crs_pkg::CRS_R_ADR0, crs_pkg::CRS_R_ADR1: begin
        put.adr[b][i[0]] = v[23:0];
      end
      crs_pkg::CRS_R_SB: put.sb = v[23:0];
      crs_pkg::CRS_R_FB: put.fbs[b] = v[23:0];
      crs_pkg::CRS_R_PC: put.pc = v[23:0];
      crs_pkg::CRS_R_VECTOR_TABLE_BASE: put.vector_table_base = v[23:0];
      crs_pkg::CRS_R_USP: put.user_stack_pointer = v[23:0];
      crs_pkg::CRS_R_ISP: put.irq_stack_pointer = v[23:0];
      // Reserved bits are not stored
      crs_pkg::CRS_R_FLG: put.processor_flags = v[15:0] & `CRS_FLG_MASK;
      crs_pkg::CRS_R_SP: begin
        if (s.processor_flags[`CRS_FLG_U]) begin
          put.user_stack_pointer = v[23:0];
        end else begin
          put.irq_stack_pointer = v[23:0];
        end
      end
      crs_pkg::CRS_R_LONG_LO: begin
        put.dat[b][0] = v[15:0];
        put.dat[b][2] = v[31:16];
      end
      crs_pkg::CRS_R_LONG_HI: begin
        put.dat[b][1] = v[15:0];
        put.dat[b][3] = v[31:16];
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Result flags

  crs_result_flags u_flags (
    .sel_i(res_sel_i),
    .size_i(res_size_i),
    .data_i(res_data_i),
    .zero_o(res_zero),
    .sign_o(res_sign)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  assign bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
  assign unmapped = |wb_adr_i[ADR_W-1:`CRS_MAP_BITS];

  always_comb begin
    logic [31:0] lane;
    logic [31:0] old;
    logic [31:0] val;
    lane = 32'h00000000;
    old = 32'h00000000;
    val = 32'h00000000;
    s_next = s_reg;
    // Bus side: answer one cycle after the request
    s_next.ack = bus_req;
    if (bus_req) begin
      s_next.bus_rd = unmapped ? 32'h00000000 :
                      rd_reg(s_reg, wb_adr_i[5:2]);
    end
    if (bus_req && wb_we_i && !unmapped) begin
      for (int k = 0; k < 4; k++) begin
        lane[8*k +: 8] = {8{wb_sel_i[k]}};
      end
      old = rd_reg(s_next, wb_adr_i[5:2]);
      s_next = put(s_next, wb_adr_i[5:2],
                   (old & ~lane) | (wb_dat_i & lane));
    end
    // Datapath write-back overrides a bus write to the same register
    if (res_en_i) begin
      old = rd_reg(s_next, res_sel_i);
      val = res_data_i;
      if (res_sel_i == crs_pkg::CRS_R_DAT0 ||
          res_sel_i == crs_pkg::CRS_R_DAT1) begin
        if (res_size_i == crs_pkg::CRS_SZ_LOW) begin
          val = {old[31:8], res_data_i[7:0]};
        end else if (res_size_i == crs_pkg::CRS_SZ_HIGH) begin
          val = {old[31:16], res_data_i[7:0], old[7:0]};
        end
      end
      s_next = put(s_next, res_sel_i, val);
    end
    if (pc_load_i) begin
      s_next.pc = pc_next_i;
    end
    // Arithmetic flags follow the result in the same cycle
    if (upd_c_i) begin
      s_next.processor_flags[`CRS_FLG_C] = carry_i;
    end
    if (upd_z_i) begin
      s_next.processor_flags[`CRS_FLG_Z] = res_zero;
    end
    if (upd_s_i) begin
      s_next.processor_flags[`CRS_FLG_S] = res_sign;
    end
    if (upd_o_i) begin
      s_next.processor_flags[`CRS_FLG_O] = ovf_i;
    end
    // Interrupt entry beats any write to the flags
    if (irq_ack_i) begin
      s_next.processor_flags[`CRS_FLG_I] = 1'b0;
      s_next.processor_flags[`CRS_FLG_U] = 1'b0;
    end
    if (swi_i) begin
      s_next.processor_flags[`CRS_FLG_I] = 1'b0;
      if (swi_num_i <= SWI_W'(`CRS_SWI_U_MAX)) begin
        s_next.processor_flags[`CRS_FLG_U] = 1'b0;
      end
    end
    s_next.rd = rd_reg(s_reg, rd_sel_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.bus_rd;
  assign rd_data_o = s_reg.rd;
  assign pc_o = s_reg.pc;
  assign vector_table_base_o = s_reg.vector_table_base;
  assign flags_o = s_reg.processor_flags;
  assign sp_o = s_reg.processor_flags[`CRS_FLG_U] ? s_reg.user_stack_pointer : s_reg.irq_stack_pointer;
  assign irq_accept_o = irq_req_i && s_reg.processor_flags[`CRS_FLG_I] &&
    (irq_pri_i > s_reg.processor_flags[`CRS_IPL_MSB:`CRS_IPL_LSB]);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  bus_ack_a: assert property (bus_req_s |=> ack_pulse_s)
    else $error("bus ack not a single pulse after request");

  pc_read_a: assert property (bus_req_s and !wb_we_i && !unmapped &&
    wb_adr_i[5:2] == crs_pkg::CRS_R_PC |=>
    wb_dat_o == {8'h00, $past(pc_o)})
    else $error("bus read of program counter wrong");

  pc_load_a: assert property (pc_load_i |=>
    pc_o == $past(pc_next_i))
    else $error("program counter load lost");

  irq_mask_a: assert property (!flags_o[`CRS_FLG_I] |->
    !irq_accept_o)
    else $error("interrupt accepted while masked");

  irq_prio_a: assert property (irq_accept_o |->
    irq_pri_i > flags_o[`CRS_IPL_MSB:`CRS_IPL_LSB])
    else $error("interrupt accepted at or below level");

  ack_enable_a: assert property (irq_ack_i |=>
    !flags_o[`CRS_FLG_I] ##1 1'b1)
    else $error("enable flag not cleared on ack");

  hw_stack_a: assert property (irq_ack_i |=>
    !flags_o[`CRS_FLG_U] && sp_o == s_reg.irq_stack_pointer)
    else $error("stack select not cleared on ack");

  swi_stack_a: assert property (swi_i &&
    swi_num_i <= SWI_W'(`CRS_SWI_U_MAX) |=> !flags_o[`CRS_FLG_U])
    else $error("stack select not cleared on low swi");

  carry_upd_a: assert property (upd_c_i |=>
    flags_o[`CRS_FLG_C] == $past(carry_i))
    else $error("carry flag not updated");

  zero_upd_a: assert property (upd_z_i &&
    res_sel_i == crs_pkg::CRS_R_LONG_LO |=>
    flags_o[`CRS_FLG_Z] == ($past(res_data_i) == 32'h00000000))
    else $error("zero flag wrong for long result");

  sign_upd_a: assert property (upd_s_i &&
    res_sel_i == crs_pkg::CRS_R_SB |=>
    flags_o[`CRS_FLG_S] == $past(res_data_i[23]))
    else $error("sign flag wrong for 24-bit result");

  ovf_upd_a: assert property (upd_o_i |=>
    flags_o[`CRS_FLG_O] == $past(ovf_i))
    else $error("overflow flag not updated");
endmodule

// ---- crs_regfile_bench.sv ----
// Self-checking testbench for the core register set
`timescale 1ns/1ps
module crs_regfile_bench;
  // Clock and reset
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  // Wishbone
  logic wb_cyc_i = 1'h0;
  logic wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  // Datapath and interrupt sequencer
  logic res_en_i = 1'h0;
  crs_pkg::crs_sel_t res_sel_i = crs_pkg::CRS_R_DAT0;
  crs_pkg::crs_size_t res_size_i = crs_pkg::CRS_SZ_WORD;
  logic [31:0] res_data_i = 32'h0;
  logic upd_c_i = 1'h0;
  logic upd_z_i = 1'h0;
  logic upd_s_i = 1'h0;
  logic upd_o_i = 1'h0;
  logic carry_i = 1'h0;
  logic ovf_i = 1'h0;
  logic pc_load_i = 1'h0;
  logic [23:0] pc_next_i = 24'h0;
  crs_pkg::crs_sel_t rd_sel_i = crs_pkg::CRS_R_DAT0;
  logic [31:0] rd_data_o;
  logic irq_req_i = 1'h0;
  logic [2:0] irq_pri_i = 3'h0;
  logic irq_accept_o;
  logic irq_ack_i = 1'h0;
  logic swi_i = 1'h0;
  logic [7:0] swi_num_i = 8'h00;
  logic [23:0] pc_o;
  logic [23:0] sp_o;
  logic [23:0] vector_table_base_o;
  logic [15:0] flags_o;
  int miscompares = 0;
  int check_count = 0;

  crs_regfile dut_u (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .res_en_i,
    .res_sel_i, .res_size_i, .res_data_i, .upd_c_i, .upd_z_i,
    .upd_s_i, .upd_o_i, .carry_i, .ovf_i, .pc_load_i, .pc_next_i,
    .rd_sel_i, .rd_data_o, .irq_req_i, .irq_pri_i, .irq_accept_o,
    .irq_ack_i, .swi_i, .swi_num_i, .pc_o, .sp_o,
    .vector_table_base_o, .flags_o
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] sl,
                     output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sl;
    // Ack and data looked at mid-cycle, as the next edge sees them
    do begin
      @(negedge clk_i);
    end while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, 4'hF, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'h0, a, 32'h0, 4'hF, q);
  endtask

  // One-cycle result write-back with flag updates and pc load
  task automatic dp(input logic [3:0] s, input logic [1:0] z,
                    input logic [31:0] d, input logic [3:0] u,
                    input logic c, o, p, input logic [23:0] pv);
    @(posedge clk_i);
    res_en_i <= 1'h1;
    res_sel_i <= crs_pkg::crs_sel_t'(s);
    res_size_i <= crs_pkg::crs_size_t'(z);
    res_data_i <= d;
    {upd_c_i, upd_z_i, upd_s_i, upd_o_i} <= u;
    carry_i <= c;
    ovf_i <= o;
    pc_load_i <= p;
    pc_next_i <= pv;
    @(posedge clk_i);
    res_en_i <= 1'h0;
    {upd_c_i, upd_z_i, upd_s_i, upd_o_i} <= 4'h0;
    pc_load_i <= 1'h0;
    @(negedge clk_i);
  endtask

  task automatic intr(input logic a, input logic s, input logic [7:0] n);
    @(posedge clk_i);
    irq_ack_i <= a;
    swi_i <= s;
    swi_num_i <= n;
    @(posedge clk_i);
    irq_ack_i <= 1'h0;
    swi_i <= 1'h0;
    @(negedge clk_i);
  endtask

  function automatic logic [31:0] msk(input int i);
    return (i < 4) ? 32'hFFFF : (i < 10) ? 32'hFFFFFF : 32'hFFFFFE;
  endfunction

  // Sign and zero of a value at a given width
  function automatic logic [1:0] zs(input int w, input logic [31:0] d);
    logic [31:0] m;
    m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
    return {d[w-1], (d & m) == 32'h0};
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    miscompares++;
    end_of_test;
  end

  initial begin
    logic [31:0] v [12];
    logic [31:0] q;
    logic [31:0] d;
    logic [23:0] pv;
    logic [3:0] cs [6] = '{4'h0, 4'h0, 4'h6, 4'hE, 4'h0, 4'h0};
    logic [1:0] cz [6] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    int cw [6] = '{16, 8, 24, 32, 16, 16};
    logic [31:0] cd [4] = '{32'h0, 32'h80, 32'h800000, 32'h0};
    void'($urandom(40));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 12; i++) begin
      rd(8'(i * 4), q);
      chk(q, 32'h0);
      v[i] = $urandom() & msk(i);
      wr(8'(i * 4), v[i] | 32'hFF000000);
      rd(8'(i * 4), q);
      chk(q, v[i]);
    end
    bus(1'h1, 8'h04, 32'hFFFFFFFF, 4'h1, q);
    v[1][7:0] = 8'hFF;
    rd(8'h04, q);
    chk(q, v[1]);
    wr(8'h40, 32'h5A5A);
    rd(8'h40, q);
    chk(q, 32'h0);
    rd(8'h00, q);
    chk(q, v[0]);
    rd(8'h38, q);
    chk(q, {v[2][15:0], v[0][15:0]});
    @(posedge clk_i);
    rd_sel_i <= crs_pkg::CRS_R_LONG_HI;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(rd_data_o, {v[3][15:0], v[1][15:0]});
    chk({8'h0, pc_o}, v[8]);
    chk({8'h0, vector_table_base_o}, v[9]);
    chk({8'h0, sp_o}, v[11]);
    dp(4'h1, 2'h1, 32'hFFA5, 4'h0, 1'h0, 1'h0, 1'h0, 24'h0);
    dp(4'h1, 2'h2, 32'hFF3C, 4'h0, 1'h0, 1'h0, 1'h0, 24'h0);
    rd(8'h04, q);
    chk(q, 32'h3CA5);
    wr(8'h30, 32'h10);
    wr(8'h00, 32'hBEEF);
    rd(8'h00, q);
    chk(q, 32'hBEEF);
    wr(8'h30, 32'h0);
    rd(8'h00, q);
    chk(q, v[0]);
    for (int k = 0; k < 6; k++) begin
      d = (k < 4) ? cd[k] : $urandom();
      dp(cs[k], cz[k], d, 4'hF, k[0], k[1], 1'h0, 24'h0);
      chk({16'h0, flags_o},
          {26'h0, k[1], 1'h0, zs(cw[k], d), 1'h0, k[0]});
    end
    pv = 24'($urandom());
    dp(4'h8, 2'h0, 32'h123456, 4'h0, 1'h0, 1'h0, 1'h1, pv);
    chk({8'h0, pc_o}, {8'h0, pv});
    wr(8'h30, 32'h30C0);
    chk({8'h0, sp_o}, v[10]);
    for (int p = 0; p < 8; p++) begin
      @(posedge clk_i);
      irq_req_i <= 1'h1;
      irq_pri_i <= 3'(p);
      @(negedge clk_i);
      chk({31'h0, irq_accept_o}, 32'(p > 3));
    end
    wr(8'h30, 32'h3080);
    @(negedge clk_i);
    chk({31'h0, irq_accept_o}, 32'h0);
    for (int t = 0; t < 3; t++) begin
      wr(8'h30, 32'h30C0);
      intr(t == 0, t > 0, (t == 1) ? 8'h1F : 8'h20);
      chk({16'h0, flags_o}, (t == 2) ? 32'h3080 : 32'h3000);
      chk({8'h0, sp_o}, (t == 2) ? v[10] : v[11]);
    end
    // Debug and reserved bits kept at zero by software
    wr(8'h30, 32'h70FD);
    rd(8'h30, q);
    chk(q & 32'h70FF, 32'h70FD);
    chk({16'h0, flags_o & 16'h70FF}, 32'h70FD);
    end_of_test;
  end
endmodule

// ---- crs_result_flags.sv ----
// Zero and sign of a write-back result at its own width
`timescale 1ns/1ps
module crs_result_flags (
  // Result
  input wire crs_pkg::crs_sel_t sel_i,
  input wire crs_pkg::crs_size_t size_i,
  input wire logic [31:0] data_i,
  // Flags
  output logic zero_o,
  output logic sign_o
);
  always_comb begin
    zero_o = (data_i[23:0] == 24'h000000);
    sign_o = data_i[23];
    unique case (sel_i)
      crs_pkg::CRS_R_LONG_LO, crs_pkg::CRS_R_LONG_HI: begin
        zero_o = (data_i == 32'h00000000);
        sign_o = data_i[31];
      end
      crs_pkg::CRS_R_DAT0, crs_pkg::CRS_R_DAT1: begin
        zero_o = (size_i == crs_pkg::CRS_SZ_WORD) ?
                 (data_i[15:0] == 16'h0000) : (data_i[7:0] == 8'h00);
        sign_o = (size_i == crs_pkg::CRS_SZ_WORD) ? data_i[15] : data_i[7];
      end
      crs_pkg::CRS_R_DAT2, crs_pkg::CRS_R_DAT3, crs_pkg::CRS_R_FLG: begin
        zero_o = (data_i[15:0] == 16'h0000);
        sign_o = data_i[15];
      end
      default: begin
        zero_o = (data_i[23:0] == 24'h000000);
        sign_o = data_i[23];
      end
    endcase
  end
endmodule
